// [logic/spod_pkg.sv]
// shared constants and types for the scan port and output-disable block
package spod_pkg;
    // ---------------------------------------------------------------
    // instruction set
    // ---------------------------------------------------------------
    localparam int IR_W = 4;
    localparam logic [3:0] INS_IDCODE = 4'h1;
    localparam logic [3:0] INS_EMU_CTRL = 4'h2;
    localparam logic [3:0] INS_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_RESET = INS_IDCODE;
    // ---------------------------------------------------------------
    // data registers
    // ---------------------------------------------------------------
    localparam int DR_W = 32;
    localparam int IDCODE_LEN = 32;
    localparam int EMU_LEN = 4;
    localparam int BYPASS_LEN = 1;
    // arbitrary identification value
    localparam logic [31:0] IDCODE_VALUE = 32'h0000_1001;
    // emulation control field positions
    localparam int EMULATION_PIN_ZERO_OE_BIT = 0;
    localparam int EMULATION_PIN_ZERO_OUT_BIT = 1;
    localparam int EMU1_OE_BIT = 2;
    localparam int EMU1_OUT_BIT = 3;
    localparam logic [3:0] EMU_CTRL_RESET = 4'h0;
    // ---------------------------------------------------------------
    // synchroniser lanes
    // ---------------------------------------------------------------
    localparam int SYN_W = 6;
    localparam int SY_TCK = 0;
    localparam int SY_TMS = 1;
    localparam int SY_TDI = 2;
    localparam int SY_TRST = 3;
    localparam int SY_EMULATION_PIN_ZERO = 4;
    localparam int SY_EMU1 = 5;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int REF_CLK_MHZ = 50;
    localparam int TCK_PERIOD_NS = 160;
    localparam int TCK_HALF_CYC = (TCK_PERIOD_NS * REF_CLK_MHZ) / 2000;
    localparam int SEQ_W = 16;
    localparam int LEN_W = 5;
    // ---------------------------------------------------------------
    // tap states, gray along the usual path
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2,
        TAP_SHIFT_DR = 4'h6,
        TAP_EXIT1_DR = 4'h7,
        TAP_PAUSE_DR = 4'h5,
        TAP_EXIT2_DR = 4'h4,
        TAP_UPD_DR = 4'hC,
        TAP_SEL_IR = 4'hD,
        TAP_CAP_IR = 4'hF,
        TAP_SHIFT_IR = 4'hE,
        TAP_EXIT1_IR = 4'hA,
        TAP_PAUSE_IR = 4'hB,
        TAP_EXIT2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } spod_tap_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_LOW = 2'h1,
        HS_HIGH = 2'h3
    } spod_hstate_t;
endpackage

// [logic/spod_if.sv]
// pin-level link between the device end and the scan controller end
`timescale 1ns/100ps
interface spod_if;
    logic tck;
    logic tms;
    logic tdi;
    logic trst;
    logic tdo_o;
    logic tdo_oe;
    logic emulation_pin_zero_dev_o;
    logic emulation_pin_zero_dev_oe;
    logic emu1_dev_o;
    logic emu1_dev_oe;
    logic emulation_pin_zero_host_o;
    logic emulation_pin_zero_host_oe;
    logic emu1_host_o;
    logic emu1_host_oe;
    logic tdo;
    logic emulation_pin_zero;
    logic emu1;
    // resolved wire levels; undriven emulation pins pull high
    assign tdo = tdo_oe ? tdo_o : 1'b1;
    assign emulation_pin_zero = emulation_pin_zero_dev_oe ? emulation_pin_zero_dev_o : (emulation_pin_zero_host_oe ? emulation_pin_zero_host_o : 1'b1);
    assign emu1 = emu1_dev_oe ? emu1_dev_o : (emu1_host_oe ? emu1_host_o : 1'b1);
    modport dev (
        input tck, tms, tdi, trst, emulation_pin_zero, emu1,
        output tdo_o, tdo_oe, emulation_pin_zero_dev_o, emulation_pin_zero_dev_oe, emu1_dev_o, emu1_dev_oe
    );
    modport host (
        input tdo, emulation_pin_zero, emu1,
        output tck, tms, tdi, trst, emulation_pin_zero_host_o, emulation_pin_zero_host_oe, emu1_host_o, emu1_host_oe
    );
endinterface

// [logic/spod_host.sv]
// scan controller end: divides its clock into the test clock and shifts sequences
`timescale 1ns/100ps
module spod_host #(
    parameter int HALF_CYC = spod_pkg::TCK_HALF_CYC
) (
    input wire logic I_REF_CLK, // reference clock
    input wire logic I_RST, // synchronous reset, high
    input wire logic I_CE, // clock enable
    spod_if.host LINK, // scan pins
    input wire logic I_TRST, // test reset level to drive
    input wire logic I_EMULATION_PIN_ZERO_OE, // drive first emulation pin
    input wire logic I_EMULATION_PIN_ZERO_O, // level on first emulation pin
    input wire logic I_EMU1_OE, // drive second emulation pin
    input wire logic I_EMU1_O, // level on second emulation pin
    input wire logic I_GO, // start a sequence
    input wire logic [15:0] I_TMS_SEQ, // mode-select bits, bit 0 first
    input wire logic [15:0] I_TDI_SEQ, // data bits, bit 0 first
    input wire logic [4:0] I_LEN, // bits minus one
    output logic O_BUSY, // sequence running
    output logic O_DONE, // pulse at end
    output logic [15:0] O_TDO_SEQ, // captured output bits
    output logic O_EMULATION_PIN_ZERO, // first emulation pin level
    output logic O_EMU1 // second emulation pin level
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        spod_pkg::spod_hstate_t st;
        logic [7:0] cnt;
        logic [4:0] idx;
        logic [4:0] len;
        logic [15:0] tms_seq;
        logic [15:0] tdi_seq;
        logic [15:0] tdo_seq;
        logic tck;
        logic done;
    } spod_hst_t;
    spod_hst_t q, d;
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.s1 = {LINK.emu1, LINK.emulation_pin_zero, LINK.tdo};
        d.s2 = q.s1;
        case (q.st)
            spod_pkg::HS_IDLE: begin
                d.tck = 1'b0;
                if (I_GO) begin
                    d.st = spod_pkg::HS_LOW;
                    d.cnt = 8'h00;
                    d.idx = 5'h00;
                    d.len = I_LEN;
                    d.tms_seq = I_TMS_SEQ;
                    d.tdi_seq = I_TDI_SEQ;
                end
            end
            spod_pkg::HS_LOW: begin
                d.cnt = q.cnt + 8'h01;
                if (q.cnt == HALF_M1) begin
                    d.cnt = 8'h00;
                    d.tck = 1'b1;
                    d.st = spod_pkg::HS_HIGH;
                end
            end
            spod_pkg::HS_HIGH: begin
                d.cnt = q.cnt + 8'h01;
                if (q.cnt == HALF_M1) begin
                    d.cnt = 8'h00;
                    // sampled late in the high phase: the answer lags our fall by about five cycles
                    d.tdo_seq[q.idx[3:0]] = q.s2[0];
                    d.tck = 1'b0;
                    d.tms_seq = {1'b1, q.tms_seq[15:1]};
                    d.tdi_seq = {1'b1, q.tdi_seq[15:1]};
                    d.idx = q.idx + 5'h01;
                    if (q.idx == q.len) begin
                        d.st = spod_pkg::HS_IDLE;
                        d.done = 1'b1;
                    end else begin
                        d.st = spod_pkg::HS_LOW;
                    end
                end
            end
            default: d.st = spod_pkg::HS_IDLE;
        endcase
    end
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            q <= '0;
        end else if (I_CE) begin
            q <= d;
        end
    end
    assign LINK.tck = q.tck;
    assign LINK.tms = q.tms_seq[0];
    assign LINK.tdi = q.tdi_seq[0];
    assign LINK.trst = I_TRST;
    // -----------------------------------------------------------------
    // emulation pins; the disable condition is for test use only
    // -----------------------------------------------------------------
    // first pin follows its enable and level inputs
    assign LINK.emulation_pin_zero_host_oe = I_EMULATION_PIN_ZERO_OE;
    assign LINK.emulation_pin_zero_host_o = I_EMULATION_PIN_ZERO_O;
    assign LINK.emu1_host_oe = I_EMU1_OE;
    assign LINK.emu1_host_o = I_EMU1_O;
    assign O_BUSY = (q.st != spod_pkg::HS_IDLE);
    assign O_DONE = q.done;
    assign O_TDO_SEQ = q.tdo_seq;
    assign O_EMULATION_PIN_ZERO = q.s2[1];
    assign O_EMU1 = q.s2[2];
endmodule

// [logic/spod_device.sv]
// device end: test access port, emulation pins and global output disable
`timescale 1ns/100ps
module spod_device (
    input wire logic I_REF_CLK, // reference clock
    input wire logic I_RST, // synchronous reset, high
    input wire logic I_CE, // clock enable
    spod_if.dev LINK, // scan pins
    input wire logic I_PROCESSOR_RESET_N, // processor reset, low
    input wire logic I_HOST_READY_OUT, // ready level from host port
    input wire logic I_HOST_INTERRUPT_OUT, // interrupt level from host port
    input wire logic [7:0] I_HOST_DATA_BUS, // data to put out
    input wire logic I_HOST_DATA_BUS_OE, // host port is outputting
    output logic O_HOST_READY_OUT, // ready pin level
    output logic O_HOST_READY_OUT_OE, // ready pin driven
    output logic O_HOST_INTERRUPT_OUT, // interrupt pin level
    output logic O_HOST_INTERRUPT_OUT_OE, // interrupt pin driven
    output logic [7:0] O_HOST_DATA_BUS, // data bus level
    output logic O_HOST_DATA_BUS_OE, // data bus driven
    output logic O_SCAN_MODE, // scan system in control
    output logic O_OUTPUT_DISABLE, // global disable active
    output logic O_EMULATION_PIN_ZERO_IRQ, // first emulation pin level in scan mode
    output logic O_EMU1_IRQ // second emulation pin level in scan mode
);
    typedef struct packed {
        // two-stage pin synchronisers
        logic [5:0] s1;
        logic [5:0] s2;
        logic tck_prev;
        // scan state
        spod_pkg::spod_tap_t tap;
        logic [3:0] ir;
        logic [3:0] ir_sh;
        logic [31:0] dr_sh;
        logic [3:0] emu_ctrl;
        logic tdo;
        logic tdo_oe;
        // host-port drivers
        logic host_ready_out;
        logic host_ready_out_oe;
        logic host_interrupt_out;
        logic host_interrupt_out_oe;
        logic [7:0] hd;
        logic hd_oe;
        // decoded pin roles
        logic off;
        logic emulation_pin_zero_irq;
        logic emu1_irq;
    } spod_dst_t;
    spod_dst_t q, d;
    // ---------------------------------------------------------------
    // synchronised pins and test-clock edges
    // ---------------------------------------------------------------
    // edges come from the synced copy, so the test clock must stay slow
    logic tck_s, tms_s, tdi_s, trst_s, emulation_pin_zero_s, emu1_s;
    logic tck_rise, tck_fall, shifting;
    assign tck_s = q.s2[spod_pkg::SY_TCK];
    assign tms_s = q.s2[spod_pkg::SY_TMS];
    assign tdi_s = q.s2[spod_pkg::SY_TDI];
    assign trst_s = q.s2[spod_pkg::SY_TRST];
    assign emulation_pin_zero_s = q.s2[spod_pkg::SY_EMULATION_PIN_ZERO];
    assign emu1_s = q.s2[spod_pkg::SY_EMU1];
    assign tck_rise = tck_s & ~q.tck_prev;
    assign tck_fall = ~tck_s & q.tck_prev;
    assign shifting = (q.tap == spod_pkg::TAP_SHIFT_DR) ||
        (q.tap == spod_pkg::TAP_SHIFT_IR);
    // ---------------------------------------------------------------
    // tap next-state function
    // ---------------------------------------------------------------
    function automatic spod_pkg::spod_tap_t tap_next(spod_pkg::spod_tap_t s, logic m);
        case (s)
            spod_pkg::TAP_RESET: tap_next = m ? spod_pkg::TAP_RESET : spod_pkg::TAP_IDLE;
            spod_pkg::TAP_IDLE: tap_next = m ? spod_pkg::TAP_SEL_DR : spod_pkg::TAP_IDLE;
            spod_pkg::TAP_SEL_DR: tap_next = m ? spod_pkg::TAP_SEL_IR : spod_pkg::TAP_CAP_DR;
            spod_pkg::TAP_CAP_DR: tap_next = m ? spod_pkg::TAP_EXIT1_DR : spod_pkg::TAP_SHIFT_DR;
            spod_pkg::TAP_SHIFT_DR: tap_next = m ? spod_pkg::TAP_EXIT1_DR : spod_pkg::TAP_SHIFT_DR;
            spod_pkg::TAP_EXIT1_DR: tap_next = m ? spod_pkg::TAP_UPD_DR : spod_pkg::TAP_PAUSE_DR;
            spod_pkg::TAP_PAUSE_DR: tap_next = m ? spod_pkg::TAP_EXIT2_DR : spod_pkg::TAP_PAUSE_DR;
            spod_pkg::TAP_EXIT2_DR: tap_next = m ? spod_pkg::TAP_UPD_DR : spod_pkg::TAP_SHIFT_DR;
            spod_pkg::TAP_UPD_DR: tap_next = m ? spod_pkg::TAP_SEL_DR : spod_pkg::TAP_IDLE;
            spod_pkg::TAP_SEL_IR: tap_next = m ? spod_pkg::TAP_RESET : spod_pkg::TAP_CAP_IR;
            spod_pkg::TAP_CAP_IR: tap_next = m ? spod_pkg::TAP_EXIT1_IR : spod_pkg::TAP_SHIFT_IR;
            spod_pkg::TAP_SHIFT_IR: tap_next = m ? spod_pkg::TAP_EXIT1_IR : spod_pkg::TAP_SHIFT_IR;
            spod_pkg::TAP_EXIT1_IR: tap_next = m ? spod_pkg::TAP_UPD_IR : spod_pkg::TAP_PAUSE_IR;
            spod_pkg::TAP_PAUSE_IR: tap_next = m ? spod_pkg::TAP_EXIT2_IR : spod_pkg::TAP_PAUSE_IR;
            spod_pkg::TAP_EXIT2_IR: tap_next = m ? spod_pkg::TAP_UPD_IR : spod_pkg::TAP_SHIFT_IR;
            spod_pkg::TAP_UPD_IR: tap_next = m ? spod_pkg::TAP_SEL_DR : spod_pkg::TAP_IDLE;
            default: tap_next = spod_pkg::TAP_RESET;
        endcase
    endfunction
    // ---------------------------------------------------------------
    // data register shift, inserting at the selected length
    // ---------------------------------------------------------------
    function automatic logic [31:0] dr_shift(logic [31:0] v, logic b, logic [3:0] ins);
        logic [31:0] r;
        // bits above the selected length fill with zero
        r = {1'b0, v[31:1]};
        case (ins)
            spod_pkg::INS_IDCODE: r[spod_pkg::IDCODE_LEN-1] = b;
            spod_pkg::INS_EMU_CTRL: r[spod_pkg::EMU_LEN-1] = b;
            default: r[spod_pkg::BYPASS_LEN-1] = b;
        endcase
        dr_shift = r;
    endfunction
    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        // pin inputs pass two flops; first stage feeds only the second
        d.s1 = {LINK.emu1, LINK.emulation_pin_zero, LINK.trst, LINK.tdi, LINK.tms, LINK.tck};
        d.s2 = q.s1;
        d.tck_prev = tck_s;
        // ---------------------------------------------------------------
        // scan logic
        // ---------------------------------------------------------------
        if (!trst_s) begin
            d.tap = spod_pkg::TAP_RESET;
            d.ir = spod_pkg::IR_RESET;
            d.emu_ctrl = spod_pkg::EMU_CTRL_RESET;
            d.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            case (q.tap)
                spod_pkg::TAP_RESET: d.ir = spod_pkg::IR_RESET;
                spod_pkg::TAP_CAP_IR: d.ir_sh = spod_pkg::IR_CAPTURE;
                spod_pkg::TAP_SHIFT_IR: d.ir_sh = {tdi_s, q.ir_sh[3:1]};
                spod_pkg::TAP_UPD_IR: d.ir = q.ir_sh;
                spod_pkg::TAP_CAP_DR: begin
                    case (q.ir)
                        spod_pkg::INS_IDCODE: d.dr_sh = spod_pkg::IDCODE_VALUE;
                        spod_pkg::INS_EMU_CTRL: d.dr_sh = {28'h0000000, q.emu_ctrl};
                        // other codes capture zero, acting as bypass
                        default: d.dr_sh = 32'h0000_0000;
                    endcase
                end
                spod_pkg::TAP_SHIFT_DR: d.dr_sh = dr_shift(q.dr_sh, tdi_s, q.ir);
                spod_pkg::TAP_UPD_DR: begin
                    if (q.ir == spod_pkg::INS_EMU_CTRL) begin
                        d.emu_ctrl = q.dr_sh[3:0];
                    end
                end
                default: d.ir = q.ir;
            endcase
            d.tap = tap_next(q.tap, tms_s);
        end else if (tck_fall) begin
            // answer lags the pin fall by three reference cycles
            // output changes on fall
            d.tdo = (q.tap == spod_pkg::TAP_SHIFT_IR) ? q.ir_sh[0] : q.dr_sh[0];
            d.tdo_oe = shifting;
        end
        // ---------------------------------------------------------------
        // global output disable and host-port drivers
        // ---------------------------------------------------------------
        // synced pins only: a pattern sampled on one edge still disables for one cycle
        // disable condition decode
        d.off = ~trst_s & emulation_pin_zero_s & ~emu1_s;
        // interrupt levels reported only while scan owns the pins
        d.emulation_pin_zero_irq = trst_s & emulation_pin_zero_s;
        d.emu1_irq = trst_s & emu1_s;
        d.host_ready_out = I_HOST_READY_OUT;
        d.host_ready_out_oe = ~d.off;
        // high in reset, floats when disabled
        d.host_interrupt_out = ~I_PROCESSOR_RESET_N | I_HOST_INTERRUPT_OUT;
        d.host_interrupt_out_oe = ~d.off;
        // data follows the port; only the enable sees the pin roles
        d.hd = I_HOST_DATA_BUS;
        d.hd_oe = I_HOST_DATA_BUS_OE & ~d.off;
    end
    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    // clock enable low freezes every field, synchronisers included
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            q <= '0;
        end else if (I_CE) begin
            q <= d;
        end
    end
    // ---------------------------------------------------------------
    // link pin drivers
    // ---------------------------------------------------------------
    // disable also floats test output
    assign LINK.tdo_oe = q.tdo_oe & trst_s & ~q.off;
    assign LINK.tdo_o = q.tdo;
    // both pin roles by test reset
    assign LINK.emulation_pin_zero_dev_oe = trst_s & q.emu_ctrl[spod_pkg::EMULATION_PIN_ZERO_OE_BIT];
    assign LINK.emulation_pin_zero_dev_o = q.emu_ctrl[spod_pkg::EMULATION_PIN_ZERO_OUT_BIT];
    assign LINK.emu1_dev_oe = trst_s & q.emu_ctrl[spod_pkg::EMU1_OE_BIT];
    assign LINK.emu1_dev_o = q.emu_ctrl[spod_pkg::EMU1_OUT_BIT];
    // ---------------------------------------------------------------
    // host-port and status outputs
    // ---------------------------------------------------------------
    assign O_HOST_READY_OUT = q.host_ready_out;
    assign O_HOST_READY_OUT_OE = q.host_ready_out_oe;
    assign O_HOST_INTERRUPT_OUT = q.host_interrupt_out;
    assign O_HOST_INTERRUPT_OUT_OE = q.host_interrupt_out_oe;
    assign O_HOST_DATA_BUS = q.hd;
    assign O_HOST_DATA_BUS_OE = q.hd_oe;
    assign O_SCAN_MODE = trst_s;
    assign O_OUTPUT_DISABLE = q.off;
    assign O_EMULATION_PIN_ZERO_IRQ = q.emulation_pin_zero_irq;
    assign O_EMU1_IRQ = q.emu1_irq;
endmodule

// [test/spod_chk.sv]
// pin assertions between the device end and the scan controller end
`timescale 1ns/100ps
module spod_chk (
    input wire logic I_REF_CLK, // reference clock
    input wire logic I_RST, // synchronous reset, high
    input wire logic i_tck, // test clock pin
    input wire logic i_trst, // test reset pin
    input wire logic i_tdo_o, // device data out level
    input wire logic i_tdo_oe, // device data out driven
    input wire logic i_emulation_pin_zero, // first emulation pin
    input wire logic i_emu1, // second emulation pin
    input wire logic i_emulation_pin_zero_dev_oe, // device drives first pin
    input wire logic i_emu1_dev_oe // device drives second pin
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);
    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    // fall only
    tdo_fall_a: assert property ($changed(i_tdo_o) |-> !$past(i_tck))
        else $error("data out moved while test clock high");
    tdo_stand_a: assert property ($rose(i_tdo_oe) && i_trst |=> (i_tdo_oe || !i_trst)[*6])
        else $error("data out enable dropped early");
    oe_fall_a: assert property ($rose(i_tdo_oe) |-> !$past(i_tck))
        else $error("data out enable rose off a fall");
    scan_only_a: assert property (i_tdo_oe |-> $past(i_trst, 3))
        else $error("data out driven outside scan");
    tdo_trst_a: assert property (!i_trst [*4] |-> !i_tdo_oe)
        else $error("data out driven with test reset low");
    emu_trst_a: assert property (!i_trst [*4] |-> !i_emulation_pin_zero_dev_oe && !i_emu1_dev_oe)
        else $error("emulation pin driven with test reset low");
    off_float_a: assert property ((!i_trst && i_emulation_pin_zero && !i_emu1) [*4]
        |-> !i_tdo_oe && !i_emulation_pin_zero_dev_oe && !i_emu1_dev_oe)
        else $error("driver active under output disable");
    emu_scan_a: assert property (i_emulation_pin_zero_dev_oe || i_emu1_dev_oe |-> $past(i_trst, 4))
        else $error("emulation pin driven without scan control");
    // -----------------------------------------------------------------
    // covers
    // -----------------------------------------------------------------
    shift_c: cover property ($rose(i_tdo_oe));
    emu_drive_c: cover property ($rose(i_emulation_pin_zero_dev_oe));
    off_c: cover property ((!i_trst && i_emulation_pin_zero && !i_emu1) [*4]);
    trst_drop_c: cover property ($fell(i_trst));
endmodule

// [test/scan_port_output_disable_tb.sv]
// self-checking bench joining both ends across the link
`timescale 1ns/100ps
module scan_port_output_disable_tb;
    logic clk, rst, go, done, busy, h_trst, h_e0_oe, h_e0, h_e1_oe, h_e1, host_emulation_pin_zero, host_emu1;
    logic [15:0] h_tms, h_tdi, tdo_seq;
    logic [4:0] h_len;
    logic prst_n, rdy_in, host_interrupt_out_in, doe_in, rdy, rdy_oe, host_interrupt_out, host_interrupt_out_oe, doe, scan, dis, irq0, irq1;
    logic [7:0] data_in, data;
    int miscompares, num_checks, cycles;
    // trst e0 e1 rst_n rdy host_interrupt_out data doe : disable rdy_oe host_interrupt_out_oe data_oe host_interrupt_out
    logic [19:0] rows [6] = '{
        {1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 8'hA5, 1'h1, 5'h0E},
        {1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'hA5, 1'h1, 5'h10},
        {1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 8'h5A, 1'h1, 5'h0F},
        {1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 8'h3C, 1'h0, 5'h0D},
        {1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 8'hC3, 1'h1, 5'h0F},
        {1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'hC3, 1'h1, 5'h11}};
    spod_if spod_if_inst ();
    spod_host spod_host_inst (.I_REF_CLK(clk), .I_RST(rst), .I_CE(1'h1), .LINK(spod_if_inst), .I_TRST(h_trst),
        .I_EMULATION_PIN_ZERO_OE(h_e0_oe), .I_EMULATION_PIN_ZERO_O(h_e0), .I_EMU1_OE(h_e1_oe), .I_EMU1_O(h_e1), .I_GO(go),
        .I_TMS_SEQ(h_tms), .I_TDI_SEQ(h_tdi), .I_LEN(h_len), .O_BUSY(busy), .O_DONE(done),
        .O_TDO_SEQ(tdo_seq), .O_EMULATION_PIN_ZERO(host_emulation_pin_zero), .O_EMU1(host_emu1));
    spod_device spod_device_inst (.I_REF_CLK(clk), .I_RST(rst), .I_CE(1'h1), .LINK(spod_if_inst),
        .I_PROCESSOR_RESET_N(prst_n), .I_HOST_READY_OUT(rdy_in), .I_HOST_INTERRUPT_OUT(host_interrupt_out_in),
        .I_HOST_DATA_BUS(data_in), .I_HOST_DATA_BUS_OE(doe_in), .O_HOST_READY_OUT(rdy),
        .O_HOST_READY_OUT_OE(rdy_oe), .O_HOST_INTERRUPT_OUT(host_interrupt_out), .O_HOST_INTERRUPT_OUT_OE(host_interrupt_out_oe),
        .O_HOST_DATA_BUS(data), .O_HOST_DATA_BUS_OE(doe), .O_SCAN_MODE(scan), .O_OUTPUT_DISABLE(dis),
        .O_EMULATION_PIN_ZERO_IRQ(irq0), .O_EMU1_IRQ(irq1));
    spod_chk spod_chk_inst (.I_REF_CLK(clk), .I_RST(rst), .i_tck(spod_if_inst.tck), .i_trst(spod_if_inst.trst),
        .i_tdo_o(spod_if_inst.tdo_o), .i_tdo_oe(spod_if_inst.tdo_oe), .i_emulation_pin_zero(spod_if_inst.emulation_pin_zero),
        .i_emu1(spod_if_inst.emu1), .i_emulation_pin_zero_dev_oe(spod_if_inst.emulation_pin_zero_dev_oe),
        .i_emu1_dev_oe(spod_if_inst.emu1_dev_oe));
    // -----------------------------------------------------------------
    // clock, timeout and shared tasks
    // -----------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ceiling well above the roughly 550 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic shift(input logic [15:0] tms, input logic [15:0] tdi, input logic [4:0] len);
        int n;
        @(negedge clk);
        h_tms = tms;
        h_tdi = tdi;
        h_len = len;
        go = 1'h1;
        @(negedge clk);
        go = 1'h0;
        check(busy, 1'h1);
        n = 0;
        // a sixteen-bit sequence needs about 130 cycles
        while (done !== 1'h1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check({busy, n < 400}, 2'h1);
    endtask
    // reset tap, idle, into shift of the identity register
    task automatic idcode_read;
        shift(16'h005F, 16'h0000, 5'h0F);
        check(tdo_seq[8:0], 9'h1FF);
        check(tdo_seq[15:9], spod_pkg::IDCODE_VALUE[6:0]);
        $display("identity scan done");
    endtask
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        {rst, go, h_trst, h_e0_oe, h_e0, h_e1_oe, h_e1, h_tms, h_tdi, h_len} = '0;
        {prst_n, rdy_in, host_interrupt_out_in, data_in, doe_in} = '0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        rst = 1'h1;
        repeat (20) @(negedge clk);
        check({doe, rdy_oe, host_interrupt_out_oe, scan}, 4'h0);
        rst = 1'h0;
        h_e0_oe = 1'h1;
        h_e1_oe = 1'h1;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            {h_trst, h_e0, h_e1, prst_n, rdy_in, host_interrupt_out_in, data_in, doe_in} = rows[i][19:5];
            repeat (6) @(negedge clk);
            check(dis, rows[i][4]);
            check({rdy_oe, rdy}, {rows[i][3], rdy_in});
            check({host_interrupt_out_oe, host_interrupt_out}, {rows[i][2], rows[i][0]});
            check({doe, data}, {rows[i][1], data_in});
            check(scan, h_trst);
            $display("row %0d done", i);
        end
        @(negedge clk);
        {h_e0_oe, h_e1_oe, h_trst} = 3'h1;
        repeat (4) @(negedge clk);
        idcode_read();
        // instruction register loads the emulation control code
        shift(16'h060F, 16'h0080, 5'h0B);
        check(tdo_seq[9:6], spod_pkg::IR_CAPTURE);
        // device takes the first pin and drives it low
        shift(16'h00C1, 16'h0008, 5'h08);
        repeat (6) @(negedge clk);
        check({spod_if_inst.emulation_pin_zero, host_emulation_pin_zero, irq0}, 3'h0);
        h_e1_oe = 1'h1;
        h_e1 = 1'h0;
        repeat (6) @(negedge clk);
        check({irq1, dis, host_emu1}, 3'h0);
        $display("emulation pins done");
        // dropping test reset releases the pin and arms the disable
        h_trst = 1'h0;
        repeat (8) @(negedge clk);
        check({spod_if_inst.emulation_pin_zero, dis}, 2'h3);
        check({rdy_oe, host_interrupt_out_oe, doe, spod_if_inst.tdo_oe}, 4'h0);
        $display("disable after scan done");
        rst = 1'h1;
        repeat (20) @(negedge clk);
        rst = 1'h0;
        h_e1_oe = 1'h0;
        h_trst = 1'h1;
        repeat (4) @(negedge clk);
        check({spod_if_inst.emulation_pin_zero, dis}, 2'h2);
        idcode_read();
        $display("second reset done");
        complete_run();
    end
endmodule
